// ==== design/dmad_top.sv ====
`include "dmad_cfg.svh"
module dmad_top #(
    parameter int FLASH_BYTES = `DMAD_FLASH_8K
) (
    // system
    input wire logic clk_i,
    input wire logic arst_n_i,
    // core data access
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic indirect_i,
    input wire dmad_pkg::dmad_mode_t mode_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [1:0] bank_sel_i,
    input wire logic bit_val_i,
    // special function space side
    input wire logic [7:0] sfs_rdata_i,
    output logic sfs_req_o,
    output logic sfs_wr_o,
    output logic [6:0] sfs_addr_o,
    output logic [7:0] sfs_wdata_o,
    // answer to core
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic bit_o,
    // program space check
    input wire logic [15:0] fetch_addr_i,
    output logic fetch_valid_o,
    output logic [6:0] fetch_sector_o
);
    import dmad_pkg::*;

    // refuse flash sizes that the bound logic was not built for
    if (FLASH_BYTES != `DMAD_FLASH_8K && FLASH_BYTES != `DMAD_FLASH_4K &&
        FLASH_BYTES != `DMAD_FLASH_2K) begin : g_bad_flash
        $error("FLASH_BYTES must be 8k, 4k or 2k");
    end

    // --------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------
    // physical RAM byte for a register operand in the chosen bank
    function automatic logic [7:0] reg_addr(input logic [1:0] bank,
                                            input logic [7:0] a);
        reg_addr = {3'h0, bank, a[2:0]};
    endfunction
    // byte holding a bit address, lsb first
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        bit_byte = `DMAD_REGS_END + {4'h0, a[6:3]};
    endfunction

    logic to_sfs;
    logic [7:0] phys;
    // route: upper half direct byte access goes out, all else to RAM
    always_comb begin
        to_sfs = addr_i[`DMAD_HALF_BIT] && !indirect_i;
        phys = addr_i;
        case (mode_i)
            DMAD_MODE_REG: begin
                to_sfs = 1'b0;
                phys = reg_addr(bank_sel_i, addr_i);
            end
            DMAD_MODE_BIT: begin
                to_sfs = 1'b0;
                phys = bit_byte(addr_i);
            end
            default: begin
            end
        endcase
    end

    // --------------------------------------------------------------
    // access sequencer
    // --------------------------------------------------------------
    dmad_ram_if ram ();
    dmad_ram dmad_ram_i (
        .clk_i(clk_i),
        .port(ram)
    );

    dmad_state_t state, next_state;
    logic sfs_req, next_sfs_req;
    logic sfs_wr, next_sfs_wr;
    logic [6:0] sfs_addr, next_sfs_addr;
    logic [7:0] sfs_wdata, next_sfs_wdata;
    logic done, next_done;
    logic [7:0] rdata, next_rdata;
    logic bit_q, next_bit;
    logic was_sfs, next_was_sfs;
    logic is_bit, next_is_bit;
    logic [2:0] bit_idx, next_bit_idx;
    logic [7:0] hold_addr, next_hold_addr;
    logic hold_val, next_hold_val;
    logic hold_wr, next_hold_wr;

    // one RAM byte at a time; bit writes read then modify
    always_comb begin
        next_state = state;
        next_sfs_req = 1'b0;
        next_sfs_wr = 1'b0;
        next_sfs_addr = sfs_addr;
        next_sfs_wdata = sfs_wdata;
        next_done = 1'b0;
        next_rdata = rdata;
        next_bit = bit_q;
        next_was_sfs = was_sfs;
        next_is_bit = is_bit;
        next_bit_idx = bit_idx;
        next_hold_addr = hold_addr;
        next_hold_val = hold_val;
        next_hold_wr = hold_wr;
        ram.we = 1'b0;
        ram.addr = phys;
        ram.wdata = wdata_i;
        case (state)
            DMAD_IDLE: begin
                if (req_i) begin
                    next_was_sfs = to_sfs;
                    next_is_bit = (mode_i == DMAD_MODE_BIT);
                    next_bit_idx = addr_i[2:0];
                    next_hold_addr = phys;
                    next_hold_val = bit_val_i;
                    next_hold_wr = wr_i;
                    if (to_sfs) begin
                        next_sfs_req = 1'b1;
                        next_sfs_wr = wr_i;
                        next_sfs_addr = addr_i[6:0];
                        next_sfs_wdata = wdata_i;
                        next_state = DMAD_READ;
                    end else if (wr_i && mode_i != DMAD_MODE_BIT) begin
                        ram.we = 1'b1;
                        next_done = 1'b1;
                    end else begin
                        next_state = DMAD_READ;
                    end
                end
            end
            DMAD_READ: begin
                ram.addr = hold_addr;
                if (was_sfs) begin
                    next_rdata = sfs_rdata_i;
                    next_done = 1'b1;
                    next_state = DMAD_IDLE;
                end else if (is_bit && hold_wr) begin
                    next_state = DMAD_WRITE;
                end else begin
                    next_rdata = ram.rdata;
                    next_bit = ram.rdata[bit_idx];
                    next_done = 1'b1;
                    next_state = DMAD_IDLE;
                end
            end
            DMAD_WRITE: begin
                ram.addr = hold_addr;
                ram.we = 1'b1;
                ram.wdata = ram.rdata;
                ram.wdata[bit_idx] = hold_val;
                next_done = 1'b1;
                next_state = DMAD_IDLE;
            end
            default: begin
                next_state = DMAD_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= DMAD_IDLE;
            sfs_req <= 1'b0;
            sfs_wr <= 1'b0;
            sfs_addr <= 7'h00;
            sfs_wdata <= 8'h00;
            done <= 1'b0;
            rdata <= 8'h00;
            bit_q <= 1'b0;
            was_sfs <= 1'b0;
            is_bit <= 1'b0;
            bit_idx <= 3'h0;
            hold_addr <= 8'h00;
            hold_val <= 1'b0;
            hold_wr <= 1'b0;
        end else begin
            state <= next_state;
            sfs_req <= next_sfs_req;
            sfs_wr <= next_sfs_wr;
            sfs_addr <= next_sfs_addr;
            sfs_wdata <= next_sfs_wdata;
            done <= next_done;
            rdata <= next_rdata;
            bit_q <= next_bit;
            was_sfs <= next_was_sfs;
            is_bit <= next_is_bit;
            bit_idx <= next_bit_idx;
            hold_addr <= next_hold_addr;
            hold_val <= next_hold_val;
            hold_wr <= next_hold_wr;
        end
    end

    assign sfs_req_o = sfs_req;
    assign sfs_wr_o = sfs_wr;
    assign sfs_addr_o = sfs_addr;
    assign sfs_wdata_o = sfs_wdata;
    assign done_o = done;
    assign rdata_o = rdata;
    assign bit_o = bit_q;

    // --------------------------------------------------------------
    // program space bound
    // --------------------------------------------------------------
    logic fetch_valid, next_fetch_valid;
    logic [6:0] fetch_sector, next_fetch_sector;
    // fetch limit and erase sector of the fetch address
    always_comb begin
        next_fetch_valid = {16'h0000, fetch_addr_i} < FLASH_BYTES;
        next_fetch_sector = fetch_addr_i[`DMAD_SECTOR_SHIFT+6:
                                         `DMAD_SECTOR_SHIFT];
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fetch_valid <= 1'b0;
            fetch_sector <= 7'h00;
        end else begin
            fetch_valid <= next_fetch_valid;
            fetch_sector <= next_fetch_sector;
        end
    end
    assign fetch_valid_o = fetch_valid;
    assign fetch_sector_o = fetch_sector;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    a_sfs_direct_route: assert property (
        state == DMAD_IDLE && req_i && mode_i == DMAD_MODE_BYTE && !indirect_i
        && addr_i[7] |=> sfs_req_o && sfs_addr_o == $past(addr_i[6:0]))
        else $error("direct upper access not sent out");
    a_indirect_ram: assert property (
        state == DMAD_IDLE && req_i && indirect_i |=> !sfs_req_o)
        else $error("indirect access left RAM");
    a_lower_ram: assert property (
        state == DMAD_IDLE && req_i && !addr_i[7] |=> !sfs_req_o)
        else $error("lower half access left RAM");
    a_done_bound: assert property (
        state == DMAD_IDLE && req_i |-> ##[1:3] done_o)
        else $error("access never completed");
    a_bank_map: assert property (
        state == DMAD_IDLE && req_i && wr_i && mode_i == DMAD_MODE_REG
        |-> ram.we && ram.addr[7:5] == 3'h0 && ram.addr[4:3] == bank_sel_i
        && ram.addr[2:0] == addr_i[2:0])
        else $error("register operand outside bank");
    a_bit_byte: assert property (
        state == DMAD_IDLE && req_i && mode_i == DMAD_MODE_BIT
        |=> ram.addr == `DMAD_REGS_END + {4'h0, $past(addr_i[6:3])})
        else $error("bit address outside bit area");
    a_bit_order: assert property (
        state == DMAD_IDLE && req_i && mode_i == DMAD_MODE_BIT
        |=> bit_idx == $past(addr_i[2:0]))
        else $error("bit index wrong");
    a_fetch_bound: assert property (
        1'b1 |=> fetch_valid_o == ({16'h0000, $past(fetch_addr_i)}
        < FLASH_BYTES))
        else $error("fetch bound wrong");
    a_sector_index: assert property (
        1'b1 |=> fetch_sector_o == $past(fetch_addr_i[15:9]))
        else $error("sector index wrong");
endmodule

// ==== design/dmad_cfg.svh ====
`ifndef DMAD_CFG_SVH
`define DMAD_CFG_SVH
// data space geometry
`define DMAD_RAM_BYTES 256
`define DMAD_HALF_BIT 7
`define DMAD_SFS_BYTES 128
`define DMAD_BANK_BYTES 8
`define DMAD_BANK_COUNT 4
`define DMAD_REGS_END 8'h20
`define DMAD_BITS_END 8'h30
// program space geometry
`define DMAD_FLASH_8K 32'h2000
`define DMAD_FLASH_4K 32'h1000
`define DMAD_FLASH_2K 32'h0800
`define DMAD_SECTOR_BYTES 512
`define DMAD_SECTOR_SHIFT 9
`endif

// ==== design/dmad_pkg.sv ====
package dmad_pkg;
    typedef enum logic [2:0] {
        DMAD_IDLE = 3'b001,
        DMAD_READ = 3'b010,
        DMAD_WRITE = 3'b100
    } dmad_state_t;
    typedef enum logic [1:0] {
        DMAD_MODE_BYTE = 2'h0,
        DMAD_MODE_BIT = 2'h1,
        DMAD_MODE_REG = 2'h2
    } dmad_mode_t;
endpackage

// ==== design/dmad_ram_if.sv ====
interface dmad_ram_if;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ==== design/dmad_ram.sv ====
module dmad_ram (
    // system
    input wire logic clk_i,
    // access port
    dmad_ram_if.mem port
);
    logic [7:0] mem_q [0:255];
    logic [7:0] rd_q;
    // synchronous write, registered read
    always_ff @(posedge clk_i) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
        rd_q <= mem_q[port.addr];
    end
    assign port.rdata = rd_q;
endmodule

// ==== verification/dmad_sfs_model.sv ====
module dmad_sfs_model (
    // system
    input wire logic clk_i,
    // special function space access
    input wire logic sfs_req_i,
    input wire logic sfs_wr_i,
    input wire logic [6:0] sfs_addr_i,
    input wire logic [7:0] sfs_wdata_i,
    output logic [7:0] sfs_rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [128];
    logic [7:0] churn;
    // preload each byte with its address folded by 5a
    initial begin
        churn = 8'h00;
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // writes land at the pulse edge; idle data changes every cycle
    always @(posedge clk_i) begin
        churn <= churn + 8'h3b;
        if (sfs_req_i && sfs_wr_i) begin
            mem[sfs_addr_i] <= sfs_wdata_i;
        end
    end
    // data is only valid while the request pulse stands
    assign sfs_rdata_o = sfs_req_i ? mem[sfs_addr_i] : churn;
endmodule

// ==== verification/tb_data_memory_address_decoder.sv ====
module tb_data_memory_address_decoder import dmad_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int FLASH = 8192;
    logic clk, arst_n, req, wr, ind, bitv, done, bit_out, fetch_valid;
    logic sfs_req, sfs_wr, seen_b, last_bit;
    dmad_mode_t mode;
    logic [7:0] addr, wdata, sfs_rdata, sfs_wdata, rdata, last_rd;
    logic [1:0] bank;
    logic [6:0] sfs_addr, fetch_sector, last_sfs;
    logic [15:0] fetch_addr;
    int errors, checked, cycles;

    // ------------------------------------------------------------
    // design and partner
    // ------------------------------------------------------------
    dmad_top #(.FLASH_BYTES(FLASH)) dmad_top_i (.clk_i(clk),
        .arst_n_i(arst_n), .req_i(req), .wr_i(wr), .indirect_i(ind),
        .mode_i(mode), .addr_i(addr), .wdata_i(wdata), .bank_sel_i(bank),
        .bit_val_i(bitv), .sfs_rdata_i(sfs_rdata), .sfs_req_o(sfs_req),
        .sfs_wr_o(sfs_wr), .sfs_addr_o(sfs_addr), .sfs_wdata_o(sfs_wdata),
        .done_o(done), .rdata_o(rdata), .bit_o(bit_out),
        .fetch_addr_i(fetch_addr), .fetch_valid_o(fetch_valid),
        .fetch_sector_o(fetch_sector));
    dmad_sfs_model dmad_sfs_model_i (.clk_i(clk), .sfs_req_i(sfs_req),
        .sfs_wr_i(sfs_wr), .sfs_addr_i(sfs_addr), .sfs_wdata_i(sfs_wdata),
        .sfs_rdata_o(sfs_rdata));

    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // a hang ends the run as a failure
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one access; waits for done and checks latency and routing
    task automatic acc(input logic w, input logic in, input dmad_mode_t m,
        input logic [7:0] a, input logic [7:0] d, input logic [1:0] bk,
        input logic bv, input int lat, input logic sfs_exp);
        int n;
        n = 0;
        seen_b = 1'b0;
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        ind <= in;
        mode <= m;
        addr <= a;
        wdata <= d;
        bank <= bk;
        bitv <= bv;
        @(posedge clk);
        req <= 1'b0;
        while (n < 8) begin
            #1;
            if (sfs_req === 1'b1) begin
                seen_b = 1'b1;
                last_sfs = sfs_addr;
            end
            if (done === 1'b1) break;
            n++;
            @(posedge clk);
        end
        chk("latency", 16'(lat), 16'(n));
        chk("sfs_route", {15'h0, sfs_exp}, {15'h0, seen_b});
        last_rd = rdata;
        last_bit = bit_out;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_lower();
        acc(1, 0, DMAD_MODE_BYTE, 8'h45, 8'hc3, 0, 0, 0, 0);
        acc(0, 1, DMAD_MODE_BYTE, 8'h45, 8'h00, 0, 0, 1, 0);
        chk("low_ind", 16'h00c3, {8'h0, last_rd});
        acc(1, 1, DMAD_MODE_BYTE, 8'h7f, 8'h3c, 0, 0, 0, 0);
        acc(0, 0, DMAD_MODE_BYTE, 8'h7f, 8'h00, 0, 0, 1, 0);
        chk("low_dir", 16'h003c, {8'h0, last_rd});
    endtask
    task automatic t_upper();
        acc(1, 1, DMAD_MODE_BYTE, 8'h90, 8'h66, 0, 0, 0, 0);
        acc(0, 0, DMAD_MODE_BYTE, 8'h90, 8'h00, 0, 0, 1, 1);
        chk("sfs_addr", 16'h0010, {9'h0, last_sfs});
        chk("sfs_rd", 16'h004a, {8'h0, last_rd});
        acc(0, 1, DMAD_MODE_BYTE, 8'h90, 8'h00, 0, 0, 1, 0);
        chk("up_ind", 16'h0066, {8'h0, last_rd});
        acc(1, 1, DMAD_MODE_BYTE, 8'hff, 8'h11, 0, 0, 0, 0);
        acc(1, 0, DMAD_MODE_BYTE, 8'hff, 8'ha5, 0, 0, 1, 1);
        acc(0, 0, DMAD_MODE_BYTE, 8'hff, 8'h00, 0, 0, 1, 1);
        chk("sfs_wr", 16'h00a5, {8'h0, last_rd});
        acc(0, 1, DMAD_MODE_BYTE, 8'hff, 8'h00, 0, 0, 1, 0);
        chk("up_keep", 16'h0011, {8'h0, last_rd});
    endtask
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            acc(1, 1, DMAD_MODE_REG, 8'hfd, 8'h80 | 8'(b), 2'(b), 0, 0,
                0);
            acc(0, 0, DMAD_MODE_BYTE, 8'(b * 8 + 5), 8'h00, 0, 0, 1,
                0);
            chk("bank", 16'h0080 | 16'(b), {8'h0, last_rd});
        end
    endtask
    task automatic t_bits();
        acc(1, 0, DMAD_MODE_BYTE, 8'h21, 8'h00, 0, 0, 0, 0);
        acc(1, 0, DMAD_MODE_BIT, 8'h0a, 8'h00, 0, 1, 2, 0);
        acc(0, 0, DMAD_MODE_BYTE, 8'h21, 8'h00, 0, 0, 1, 0);
        chk("bit_set", 16'h0004, {8'h0, last_rd});
        acc(1, 0, DMAD_MODE_BYTE, 8'h2f, 8'h80, 0, 0, 0, 0);
        acc(0, 0, DMAD_MODE_BIT, 8'h7f, 8'h00, 0, 0, 1, 0);
        chk("bit_127", 16'h0001, {15'h0, last_bit});
        acc(0, 0, DMAD_MODE_BIT, 8'h7e, 8'h00, 0, 0, 1, 0);
        chk("bit_126", 16'h0000, {15'h0, last_bit});
    endtask
    task automatic t_fetch();
        logic [15:0] tab [5] = '{16'h0000, 16'h01ff, 16'h1fff, 16'h2000,
            16'hffff};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            fetch_addr <= tab[i];
            @(posedge clk);
            #1;
            chk("fvalid", {15'h0, tab[i] < 16'(FLASH)},
                {15'h0, fetch_valid});
            chk("sector", {9'h0, tab[i][15:9]}, {9'h0, fetch_sector});
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        checked = 0;
        cycles = 0;
        {req, wr, ind, bitv, addr, wdata, bank, fetch_addr} = '0;
        mode = DMAD_MODE_BYTE;
        arst_n = 1'b0;
        repeat (8) @(posedge clk);
        chk("rst_outs", 16'h0, {done, sfs_req, fetch_valid, 5'h0, rdata});
        arst_n <= 1'b1;
        t_lower();
        t_upper();
        t_banks();
        t_bits();
        t_fetch();
        complete_run();
    end
endmodule
